// >>> src/smc_pkg.sv
/*
 smc_pkg: constants shared by the standby mode controller.
 assumes: a single 125 MHz clock, avalon-mm register access.
*/
package smc_pkg;
   // clock rate
   localparam int CLK_MHZ = 125;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h38;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h3c;
   localparam logic [7:0] ADDR_TBASE = 8'h40;
   localparam logic [7:0] ADDR_STATUS = 8'h44;
   localparam logic [7:0] ADDR_COMMAND = 8'h48;
   // control one fields
   localparam int BIT_HALT = 7;
   localparam int BIT_WAKE_METHOD = 6;
   localparam int BIT_RETURN_MODE = 5;
   localparam int BIT_PORT_HOLD = 4;
   localparam int BIT_WARMUP_HI = 3;
   localparam int BIT_WARMUP_LO = 2;
   // control two fields
   localparam int BIT_FAST_OSC = 7;
   localparam int BIT_SLOW_OSC = 6;
   localparam int BIT_SYS_CLK = 5;
   localparam int BIT_DOZE = 4;
   localparam int BIT_GATE = 2;
   // time base control fields
   localparam int BIT_TB_ENABLE = 7;
   localparam int BIT_TB_IRQ_EN = 6;
   localparam int BIT_MASTER_IRQ = 5;
   localparam int BIT_TB_SRC_HI = 1;
   localparam int BIT_TB_SRC_LO = 0;
   // command register: bit 0 clears the time base irq latch
   localparam int BIT_CMD_IRQ_CLR = 0;
   // reset values
   localparam logic [7:0] RST_CTRL_ONE = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO = 8'h80;
   localparam logic [7:0] RST_TBASE = 8'h00;
   // undefined low bits of control one read as this pattern
   localparam logic [1:0] CTRL_ONE_UNDEF = 2'h0;
   // warm-up lengths in oscillator periods per code, fast then slow
   localparam int WARM_CNT_W = 18;
   localparam logic [WARM_CNT_W-1:0] WARM_F00 = 18'h00c00; // 3 x 2^10
   localparam logic [WARM_CNT_W-1:0] WARM_F01 = 18'h10000; // 2^16
   localparam logic [WARM_CNT_W-1:0] WARM_F10 = 18'h0c000; // 3 x 2^14
   localparam logic [WARM_CNT_W-1:0] WARM_F11 = 18'h04000; // 2^14
   localparam logic [WARM_CNT_W-1:0] WARM_S00 = 18'h06000; // 3 x 2^13
   localparam logic [WARM_CNT_W-1:0] WARM_S01 = 18'h02000; // 2^13
   localparam logic [WARM_CNT_W-1:0] WARM_S10 = 18'h000c0; // 3 x 2^6
   localparam logic [WARM_CNT_W-1:0] WARM_S11 = 18'h00040; // 2^6
   // operating modes
   typedef enum logic [3:0] {
      SMC_FAST_RUN_SINGLE,
      SMC_FAST_RUN_DUAL,
      SMC_SLOW_RUN_DUAL,
      SMC_SLOW_RUN_LONE,
      SMC_FAST_DOZE_SINGLE,
      SMC_FAST_DOZE_DUAL,
      SMC_SLOW_DOZE_DUAL,
      SMC_SLOW_DOZE_LONE,
      SMC_FAST_GATE,
      SMC_SLOW_GATE_MODE,
      SMC_DEEP_HALT,
      SMC_WARMUP
   } smc_mode_e;
endpackage : smc_pkg

// >>> src/smc_edge_sync.sv
/*
 smc_edge_sync: two-flop synchroniser with rise and fall pulses.
 assumes: input is asynchronous to clk; outputs are in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_edge_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // asynchronous input
   input wire logic async_in,
   // synchronised level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // only sync_reg looks at meta_reg, so metastability never fans out
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // edge pulses from the settled copies
   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule : smc_edge_sync
`default_nettype wire

// >>> src/smc_standby_ctrl.sv
/*
 smc_standby_ctrl: operating mode controller with doze, gate and deep
 halt states, warm-up timing and an avalon-mm register slave.
 assumes: fast and slow oscillator ticks and the time base source clock
 arrive as pins and are synchronised here; the reset pin is seen as rst.
*/
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - fast dual doze: oscillators on, cpu/watchdog halted, returns fast dual
// - slow lone doze: only slow oscillator on, cpu halted, returns slow lone
// - in slow lone run and doze, divider stages one to six freeze
// - slow dual doze is like slow lone doze but fast oscillator runs
// - writing one to the gate bit enters gated mode; only time base clocked
// - gated mode ends on falling edge of the selected time base source
// - slow gated mode returns to slow lone run, fast gated mode to fast single run, whatever time base enable is
// - time base enabled at gate entry sets its irq latch after return
// - deep halt stops oscillators and holds all internal state
// - deep halt ends on wake pin, then warm-up, then resume
// - halt bit 7 of control one at 38h starts deep halt
// - wake method bit 6: zero edge, one level release
// - return mode bit 5: zero fast run, one slow lone run
// - port hold bit 4: zero ports high impedance, one ports driven
// - warm-up length from bits 3:2, separate fast and slow tables
// - reset during deep halt always comes up in fast single run
// - bits 0 and 1 of control one read undefined
// - port hold zero forces port inputs to zero during deep halt
// - shared wake pin goes high impedance in deep halt always
// - doze modes end on an interrupt request
// - release of gated mode clears the gate bit
// - release of a doze mode clears the doze bit
module smc_standby_ctrl
   import smc_pkg::*;
#(
   parameter int PORT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // oscillator ticks and time base source clocks (pins)
   input wire logic fast_tick,
   input wire logic slow_tick,
   input wire logic [3:0] tbase_src_clk,
   // wake pin and interrupt requests
   input wire logic shared_wake_pin,
   input wire logic irq_request,
   // ports
   input wire logic [PORT_W-1:0] port_in_raw,
   output logic [PORT_W-1:0] port_in_gated,
   output logic port_oe_n,
   output logic wake_pin_oe_n,
   // clock controls
   output logic fast_osc_on,
   output logic slow_osc_on,
   output logic cpu_clk_en,
   output logic wdt_clk_en,
   output logic periph_clk_en,
   output logic tbase_clk_en,
   output logic divider_low_en,
   output logic sys_clk_slow,
   output logic tbase_irq
);
   import smc_pkg::*;

   smc_mode_e mode_reg;
   logic [7:0] ctrl_one_reg;
   logic [7:0] ctrl_two_reg;
   logic [7:0] tbase_reg;
   logic tb_armed_reg;
   logic irq_set_pending_reg;
   logic tbase_irq_reg;
   logic [WARM_CNT_W-1:0] warm_cnt_reg;
   logic warm_slow_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic wake_lvl;
   logic wake_rise;
   logic tb_fall;
   logic fast_lvl;
   logic fast_rise;
   logic slow_rise;
   logic [3:0] tb_sync_lvl;
   logic [3:0] tb_sync_fall;
   logic wake_event;
   logic wr_ctrl_one;
   logic wr_ctrl_two;
   logic wr_tbase;
   logic wr_cmd;
   logic warm_tick;
   logic gate_exit;
   logic doze_exit;
   logic halt_exit;
   logic [WARM_CNT_W-1:0] warm_len;

   // synchronisers for the wake pin and both oscillator ticks
   smc_edge_sync u_wake (.clk(clk), .rst(rst), .async_in(shared_wake_pin),
      .level(wake_lvl), .rise(wake_rise), .fall());
   smc_edge_sync u_fast (.clk(clk), .rst(rst), .async_in(fast_tick),
      .level(fast_lvl), .rise(fast_rise), .fall());
   smc_edge_sync u_slow (.clk(clk), .rst(rst), .async_in(slow_tick),
      .level(), .rise(slow_rise), .fall());

   // one synchroniser per selectable time base source
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_tb
         smc_edge_sync u_tb (.clk(clk), .rst(rst),
            .async_in(tbase_src_clk[gi]), .level(tb_sync_lvl[gi]),
            .rise(), .fall(tb_sync_fall[gi]));
      end
   endgenerate

   // selected source falling edge
   assign tb_fall = tb_sync_fall[tbase_reg[BIT_TB_SRC_HI:BIT_TB_SRC_LO]];

   // writes land on the edge that completes the transfer (waitrequest low)
   assign wr_ctrl_one = avs_write & ack_reg & (avs_address == ADDR_CTRL_ONE);
   assign wr_ctrl_two = avs_write & ack_reg & (avs_address == ADDR_CTRL_TWO);
   assign wr_tbase = avs_write & ack_reg & (avs_address == ADDR_TBASE);
   assign wr_cmd = avs_write & ack_reg & (avs_address == ADDR_COMMAND);
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

   // release conditions
   assign wake_event = ctrl_one_reg[BIT_WAKE_METHOD] ? wake_lvl
                                                     : wake_rise;
   assign gate_exit = (mode_reg == SMC_SLOW_GATE_MODE ||
                       mode_reg == SMC_FAST_GATE) && tb_fall;
   assign doze_exit = (mode_reg == SMC_FAST_DOZE_SINGLE ||
                       mode_reg == SMC_FAST_DOZE_DUAL ||
                       mode_reg == SMC_SLOW_DOZE_DUAL ||
                       mode_reg == SMC_SLOW_DOZE_LONE) && irq_request;
   assign halt_exit = (mode_reg == SMC_WARMUP) && warm_tick &&
                      (warm_cnt_reg == '0);

   // warm-up counts oscillator periods of the clock it returns on
   assign warm_tick = warm_slow_reg ? slow_rise : fast_rise;

   // warm-up length lookup
   always_comb begin
      case (ctrl_one_reg[BIT_WARMUP_HI:BIT_WARMUP_LO])
         2'h0: warm_len = ctrl_one_reg[BIT_RETURN_MODE] ? WARM_S00 : WARM_F00;
         2'h1: warm_len = ctrl_one_reg[BIT_RETURN_MODE] ? WARM_S01 : WARM_F01;
         2'h2: warm_len = ctrl_one_reg[BIT_RETURN_MODE] ? WARM_S10 : WARM_F10;
         default: warm_len = ctrl_one_reg[BIT_RETURN_MODE] ? WARM_S11
                                                           : WARM_F11;
      endcase
   end

   // control one: halt bit self-clears when the warm-up ends
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_one_reg <= RST_CTRL_ONE;
      end else if (wr_ctrl_one) begin
         ctrl_one_reg <= {avs_writedata[7:2], 2'h0};
      end else if (halt_exit) begin
         ctrl_one_reg[BIT_HALT] <= 1'b0;
      end
   end

   // control two: doze and gate bits clear on release; release wins
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_two_reg <= RST_CTRL_TWO;
      end else begin
         if (wr_ctrl_two) begin
            ctrl_two_reg <= avs_writedata[7:0];
         end
         if (gate_exit) begin
            ctrl_two_reg[BIT_GATE] <= 1'b0;
         end
         if (doze_exit) begin
            ctrl_two_reg[BIT_DOZE] <= 1'b0;
         end
      end
   end

   // time base control
   always_ff @(posedge clk) begin
      if (rst) begin
         tbase_reg <= RST_TBASE;
      end else if (wr_tbase) begin
         tbase_reg <= avs_writedata[7:0];
      end
   end

   // mode sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= SMC_FAST_RUN_SINGLE;
         warm_cnt_reg <= '0;
         warm_slow_reg <= 1'b0;
         tb_armed_reg <= 1'b0;
      end else begin
         case (mode_reg)
            SMC_FAST_RUN_SINGLE, SMC_FAST_RUN_DUAL, SMC_SLOW_RUN_DUAL,
            SMC_SLOW_RUN_LONE: begin
               if (ctrl_one_reg[BIT_HALT]) begin
                  mode_reg <= SMC_DEEP_HALT;
               end else if (ctrl_two_reg[BIT_GATE]) begin
                  tb_armed_reg <= tbase_reg[BIT_TB_ENABLE];
                  mode_reg <= ctrl_two_reg[BIT_SYS_CLK] ? SMC_SLOW_GATE_MODE
                                                        : SMC_FAST_GATE;
               end else if (ctrl_two_reg[BIT_DOZE]) begin
                  case (mode_reg)
                     SMC_FAST_RUN_SINGLE: mode_reg <= SMC_FAST_DOZE_SINGLE;
                     SMC_FAST_RUN_DUAL: mode_reg <= SMC_FAST_DOZE_DUAL;
                     SMC_SLOW_RUN_DUAL: mode_reg <= SMC_SLOW_DOZE_DUAL;
                     default: mode_reg <= SMC_SLOW_DOZE_LONE;
                  endcase
               end else if (ctrl_two_reg[BIT_SYS_CLK]) begin
                  mode_reg <= ctrl_two_reg[BIT_FAST_OSC] ? SMC_SLOW_RUN_DUAL
                                                         : SMC_SLOW_RUN_LONE;
               end else begin
                  mode_reg <= ctrl_two_reg[BIT_SLOW_OSC] ? SMC_FAST_RUN_DUAL
                                                         : SMC_FAST_RUN_SINGLE;
               end
            end
            SMC_FAST_DOZE_SINGLE: begin
               if (doze_exit) mode_reg <= SMC_FAST_RUN_SINGLE;
            end
            SMC_FAST_DOZE_DUAL: begin
               if (doze_exit) mode_reg <= SMC_FAST_RUN_DUAL;
            end
            SMC_SLOW_DOZE_DUAL: begin
               if (doze_exit) mode_reg <= SMC_SLOW_RUN_DUAL;
            end
            SMC_SLOW_DOZE_LONE: begin
               if (doze_exit) mode_reg <= SMC_SLOW_RUN_LONE;
            end
            SMC_FAST_GATE: begin
               if (gate_exit) mode_reg <= SMC_FAST_RUN_SINGLE;
            end
            SMC_SLOW_GATE_MODE: begin
               if (gate_exit) mode_reg <= SMC_SLOW_RUN_LONE;
            end
            SMC_DEEP_HALT: begin
               if (wake_event) begin
                  warm_cnt_reg <= warm_len - 18'h1;
                  warm_slow_reg <= ctrl_one_reg[BIT_RETURN_MODE];
                  mode_reg <= SMC_WARMUP;
               end
            end
            SMC_WARMUP: begin
               if (warm_tick) begin
                  if (warm_cnt_reg == '0) begin
                     mode_reg <= warm_slow_reg ? SMC_SLOW_RUN_LONE
                               : (ctrl_two_reg[BIT_SLOW_OSC]
                                  ? SMC_FAST_RUN_DUAL : SMC_FAST_RUN_SINGLE);
                  end else begin
                     warm_cnt_reg <= warm_cnt_reg - 18'h1;
                  end
               end
            end
            default: mode_reg <= SMC_FAST_RUN_SINGLE;
         endcase
      end
   end

   // time base irq latch: hardware set wins over software clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_set_pending_reg <= 1'b0;
         tbase_irq_reg <= 1'b0;
      end else begin
         irq_set_pending_reg <= gate_exit & tb_armed_reg;
         if (irq_set_pending_reg) begin
            tbase_irq_reg <= 1'b1;
         end else if (wr_cmd && avs_writedata[BIT_CMD_IRQ_CLR]) begin
            tbase_irq_reg <= 1'b0;
         end
      end
   end

   // serviced only when both enables are set
   assign tbase_irq = tbase_irq_reg & tbase_reg[BIT_TB_IRQ_EN] &
                      tbase_reg[BIT_MASTER_IRQ];

   // bus answer one cycle after the request appears
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
         if (avs_read && !ack_reg) begin
            case (avs_address)
               ADDR_CTRL_ONE: rdata_reg <= {24'h0, ctrl_one_reg[7:2],
                                            CTRL_ONE_UNDEF};
               ADDR_CTRL_TWO: rdata_reg <= {24'h0, ctrl_two_reg};
               ADDR_TBASE: rdata_reg <= {24'h0, tbase_reg};
               ADDR_STATUS: rdata_reg <= {23'h0, tbase_irq_reg,
                                          3'h0, tb_sync_lvl[0],
                                          mode_reg};
               default: rdata_reg <= 32'h0;
            endcase
         end
      end
   end
   assign avs_readdata = rdata_reg;

   // clock enables per mode; divider low stages freeze in slow lone modes
   always_comb begin
      fast_osc_on = 1'b1;
      slow_osc_on = ctrl_two_reg[BIT_SLOW_OSC];
      cpu_clk_en = 1'b0;
      periph_clk_en = 1'b1;
      tbase_clk_en = 1'b1;
      divider_low_en = 1'b1;
      sys_clk_slow = 1'b0;
      case (mode_reg)
         SMC_FAST_RUN_SINGLE, SMC_FAST_RUN_DUAL: cpu_clk_en = 1'b1;
         SMC_SLOW_RUN_DUAL: begin
            cpu_clk_en = 1'b1;
            sys_clk_slow = 1'b1;
         end
         SMC_SLOW_RUN_LONE, SMC_SLOW_DOZE_LONE: begin
            cpu_clk_en = (mode_reg == SMC_SLOW_RUN_LONE);
            fast_osc_on = 1'b0;
            divider_low_en = 1'b0;
            sys_clk_slow = 1'b1;
         end
         SMC_SLOW_DOZE_DUAL: sys_clk_slow = 1'b1;
         SMC_FAST_GATE, SMC_SLOW_GATE_MODE: begin
            periph_clk_en = 1'b0;
            sys_clk_slow = (mode_reg == SMC_SLOW_GATE_MODE);
         end
         SMC_DEEP_HALT: begin
            fast_osc_on = 1'b0;
            slow_osc_on = 1'b0;
            periph_clk_en = 1'b0;
            tbase_clk_en = 1'b0;
            divider_low_en = 1'b0;
         end
         SMC_WARMUP: begin
            fast_osc_on = ~warm_slow_reg | ctrl_two_reg[BIT_FAST_OSC];
            slow_osc_on = warm_slow_reg | ctrl_two_reg[BIT_SLOW_OSC];
            periph_clk_en = 1'b0;
            tbase_clk_en = 1'b0;
         end
         default: cpu_clk_en = 1'b0;
      endcase
   end
   assign wdt_clk_en = cpu_clk_en;

   // ports float or hold during halt and warm-up; wake pin always floats
   wire in_halt = (mode_reg == SMC_DEEP_HALT) || (mode_reg == SMC_WARMUP);
   assign port_oe_n = in_halt & ~ctrl_one_reg[BIT_PORT_HOLD];
   assign wake_pin_oe_n = in_halt;
   assign port_in_gated = port_oe_n ? '0 : port_in_raw;

   // assertions
   a_gate_ends_slow: assert property (@(posedge clk) disable iff (rst)
      (mode_reg == SMC_SLOW_GATE_MODE && tb_fall) |=>
      mode_reg == SMC_SLOW_RUN_LONE && !ctrl_two_reg[BIT_GATE])
      else $error("gated mode did not return to slow lone run");
   a_irq_after_gate: assert property (@(posedge clk) disable iff (rst)
      (gate_exit && tb_armed_reg) |-> ##2 tbase_irq_reg)
      else $error("time base irq latch not set after gated mode");
   a_halt_osc_off: assert property (@(posedge clk) disable iff (rst)
      mode_reg == SMC_DEEP_HALT |-> !fast_osc_on && !slow_osc_on)
      else $error("oscillator running in deep halt");
   a_halt_entry: assert property (@(posedge clk) disable iff (rst)
      (ctrl_one_reg[BIT_HALT] && mode_reg == SMC_FAST_RUN_SINGLE)
      |=> mode_reg == SMC_DEEP_HALT)
      else $error("halt bit did not start deep halt");
   a_slow_return: assert property (@(posedge clk) disable iff (rst)
      (halt_exit && warm_slow_reg) |=> mode_reg == SMC_SLOW_RUN_LONE)
      else $error("wrong mode after warm-up");
   a_wake_pin_float: assert property (@(posedge clk) disable iff (rst)
      $rose(in_halt) |-> wake_pin_oe_n && (port_oe_n ==
      !ctrl_one_reg[BIT_PORT_HOLD]))
      else $error("pin drive wrong in deep halt");
   a_doze_clear: assert property (@(posedge clk) disable iff (rst)
      doze_exit |=> !ctrl_two_reg[BIT_DOZE] && cpu_clk_en)
      else $error("doze release did not clear doze bit");
   a_divider_freeze: assert property (@(posedge clk) disable iff (rst)
      mode_reg == SMC_SLOW_DOZE_LONE |-> !divider_low_en && !cpu_clk_en)
      else $error("divider low stages run in slow lone doze");
endmodule : smc_standby_ctrl
`default_nettype wire

// >>> test/smc_osc_model.sv
/*
 smc_osc_model: board side of the controller: both oscillators, the time
 base source clocks and the wake pin.
 assumes: oscillator enables come from the controller; firmware drives
 wake_cmd.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_osc_model (
   // oscillator enables from the controller
   input wire logic fast_osc_on,
   input wire logic slow_osc_on,
   // firmware request on the wake pin
   input wire logic wake_cmd,
   // pins towards the controller
   output logic fast_tick,
   output logic slow_tick,
   output logic [3:0] tbase_src_clk,
   output logic shared_wake_pin
);
   // fast oscillator: stands low while stopped, phase unrelated to clk
   initial begin
      fast_tick = 1'b0;
      forever #9 fast_tick = (fast_osc_on === 1'b1) & ~fast_tick;
   end
   // slow oscillator: same, 60 ns period keeps each phase above a clk
   initial begin
      slow_tick = 1'b0;
      forever #30 slow_tick = (slow_osc_on === 1'b1) & ~slow_tick;
   end
   // time base sources run free, a fall every 400 ns
   initial begin
      tbase_src_clk = 4'h0;
      forever #200 tbase_src_clk = ~tbase_src_clk;
   end
   // no key wake inputs exist here, so edge release stays legal
   assign shared_wake_pin = wake_cmd;
endmodule : smc_osc_model
`default_nettype wire

// >>> test/tb_standby_mode_controller.sv
/*
 tb_standby_mode_controller: self-checking bench of smc_standby_ctrl.
 assumes: smc_pkg, smc_standby_ctrl and smc_osc_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_standby_mode_controller;
   import smc_pkg::*;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, irq_request;
   logic wake_cmd, shared_wake_pin, fast_tick, slow_tick, port_oe_n;
   logic fast_osc_on, slow_osc_on, cpu_clk_en, wdt_clk_en, periph_clk_en;
   logic tbase_clk_en, divider_low_en, sys_clk_slow, tbase_irq;
   logic wake_pin_oe_n;
   logic [7:0] avs_address, port_in_raw, port_in_gated;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] tbase_src_clk;
   int err_total, n_tests;
   smc_standby_ctrl smc_standby_ctrl_i (.clk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .fast_tick, .slow_tick, .tbase_src_clk,
      .shared_wake_pin, .irq_request, .port_in_raw, .port_in_gated,
      .port_oe_n, .wake_pin_oe_n, .fast_osc_on, .slow_osc_on, .cpu_clk_en,
      .wdt_clk_en, .periph_clk_en, .tbase_clk_en, .divider_low_en,
      .sys_clk_slow, .tbase_irq);
   smc_osc_model smc_osc_model_i (.fast_osc_on, .slow_osc_on, .wake_cmd,
      .fast_tick, .slow_tick, .tbase_src_clk, .shared_wake_pin);
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // one avalon transfer; waitrequest and read data taken at rising edges
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk);
      end
      rd = avs_readdata;
      chk(n < 50, 1, "bus hang");
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic mode_is(input smc_mode_e m);
      bus(0, ADDR_STATUS, 8'h00);
      chk({28'h0, rd[3:0]}, {28'h0, m}, "mode");
   endtask : mode_is
   // counts cycles until the cpu clock comes back, bounded by lim
   task automatic wait_up(input int lim, output int n);
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(n < lim, 1, "no wake");
   endtask : wait_up
   task automatic t_reset();
      bus(0, ADDR_CTRL_ONE, 8'h00);
      chk(rd, {24'h0, RST_CTRL_ONE}, "ctrl one rst");
      bus(0, ADDR_CTRL_TWO, 8'h00);
      chk(rd, {24'h0, RST_CTRL_TWO}, "ctrl two rst");
      chk({fast_osc_on, slow_osc_on, cpu_clk_en, port_oe_n, tbase_irq},
         5'b10100, "rst outs");
      bus(1, 8'h4c, 8'hff);
      bus(0, 8'h4c, 8'h00);
      chk(rd, 0, "unmapped");
      bus(1, ADDR_CTRL_ONE, 8'h3f);
      bus(0, ADDR_CTRL_ONE, 8'h00);
      chk(rd, {24'h0, 6'h0f, CTRL_ONE_UNDEF}, "low bits");
      bus(1, ADDR_CTRL_ONE, 8'h00);
      $display("test reset done");
   endtask : t_reset
   // fast dual, slow lone, slow dual and fast single doze, irq wakes each
   task automatic t_doze();
      logic [7:0] rv [4] = '{8'hc0, 8'h60, 8'he0, 8'h80};
      smc_mode_e dz [4] = '{SMC_FAST_DOZE_DUAL, SMC_SLOW_DOZE_LONE,
         SMC_SLOW_DOZE_DUAL, SMC_FAST_DOZE_SINGLE};
      smc_mode_e rn [4] = '{SMC_FAST_RUN_DUAL, SMC_SLOW_RUN_LONE,
         SMC_SLOW_RUN_DUAL, SMC_FAST_RUN_SINGLE};
      int n;
      for (int i = 0; i < 4; i++) begin
         bus(1, ADDR_CTRL_TWO, rv[i]);
         bus(1, ADDR_CTRL_TWO, rv[i] | 8'h10);
         mode_is(dz[i]);
         chk({cpu_clk_en, wdt_clk_en, periph_clk_en, fast_osc_on,
            sys_clk_slow}, {3'b001, rv[i][7], rv[i][5]}, "doze");
         if (i == 1)
            chk(divider_low_en, 0, "divider");
         @(posedge clk);
         irq_request <= 1'b1;
         wait_up(20, n);
         @(posedge clk);
         irq_request <= 1'b0;
         mode_is(rn[i]);
         bus(0, ADDR_CTRL_TWO, 8'h00);
         chk(rd, {24'h0, rv[i]}, "doze bit");
      end
      $display("test doze done");
   endtask : t_doze
   // gated mode with the time base off, then on
   task automatic t_gate();
      int n;
      // fast counterpart first: ends on the same source fall
      bus(1, ADDR_CTRL_TWO, 8'h84);
      repeat (2) @(negedge clk);
      chk(periph_clk_en, 0, "fast gate");
      wait_up(60, n);
      mode_is(SMC_FAST_RUN_SINGLE);
      bus(0, ADDR_CTRL_TWO, 8'h00);
      chk(rd, 32'h80, "fast gate bit");
      bus(1, ADDR_CTRL_TWO, 8'h60);
      for (int e = 0; e < 2; e++) begin
         bus(1, ADDR_TBASE, e ? 8'h80 : 8'h00);
         @(posedge tbase_src_clk[0]);
         bus(1, ADDR_CTRL_TWO, 8'h64);
         repeat (2) @(negedge clk);
         chk({cpu_clk_en, periph_clk_en, tbase_clk_en}, 1, "gate");
         wait_up(60, n);
         repeat (3) @(posedge clk);
         mode_is(SMC_SLOW_RUN_LONE);
         bus(0, ADDR_CTRL_TWO, 8'h00);
         chk(rd, 32'h60, "gate bit");
         bus(0, ADDR_STATUS, 8'h00);
         chk(rd[8], e, "latch");
      end
      bus(1, ADDR_TBASE, 8'he0);
      @(negedge clk);
      chk(tbase_irq, 1, "irq");
      bus(1, ADDR_COMMAND, 8'h01);
      @(negedge clk);
      chk(tbase_irq, 0, "irq clr");
      bus(1, ADDR_TBASE, 8'h00);
      $display("test gate done");
   endtask : t_gate
   // deep halt from slow run: edge wake, ports float, shortest slow warm-up
   task automatic t_halt_slow();
      int n;
      bus(1, ADDR_CTRL_ONE, 8'hac);
      repeat (2) @(negedge clk);
      chk({port_oe_n, wake_pin_oe_n, slow_osc_on, cpu_clk_en}, 4'hc,
         "halt");
      chk(port_in_gated, 0, "port in");
      @(posedge clk);
      wake_cmd <= 1'b1;
      wait_up(2000, n);
      chk(n >= 470 && n <= 530, 1, "slow warm");
      mode_is(SMC_SLOW_RUN_LONE);
      bus(0, ADDR_CTRL_ONE, 8'h00);
      chk(rd, 32'h2c, "halt clr");
      wake_cmd <= 1'b0;
      $display("test halt slow done");
   endtask : t_halt_slow
   // deep halt from fast run: level wake, ports held, fast code 3 (2^14 periods)
   task automatic t_halt_fast();
      int n;
      bus(1, ADDR_CTRL_TWO, 8'h80);
      bus(1, ADDR_CTRL_ONE, 8'hdc);
      repeat (2) @(negedge clk);
      chk({port_oe_n, wake_pin_oe_n, fast_osc_on}, 3'b010, "hold");
      chk(port_in_gated, 32'ha5, "port kept");
      @(posedge clk);
      wake_cmd <= 1'b1;
      wait_up(45000, n);
      chk(n > 36000 && n < 38000, 1, "fast warm");
      mode_is(SMC_FAST_RUN_SINGLE);
      wake_cmd <= 1'b0;
      // reset pin ends a deep halt taken with slow return selected
      bus(1, ADDR_CTRL_ONE, 8'ha0);
      repeat (4) @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      mode_is(SMC_FAST_RUN_SINGLE);
      $display("test halt fast done");
   endtask : t_halt_fast
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   // watchdog: the fast warm-up dominates, about 37k cycles of the 60k cycle limit
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      give_verdict();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      {avs_read, avs_write, irq_request, wake_cmd} = 4'h0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      port_in_raw = 8'ha5;
      err_total = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_doze();
      t_gate();
      t_halt_slow();
      t_halt_fast();
      give_verdict();
   end
endmodule : tb_standby_mode_controller
`default_nettype wire
